// File: verilog/codec_clock_pkg.sv
// codec clock and rate register constants: offsets, fields, reset values
// assumes an 8-bit register file behind a classic wishbone slave
package codec_clock_pkg;

  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned REG_WIDTH  = 8;

  // register offsets (byte addresses = 4 x index)
  localparam logic [7:0] IDX_PAGE_SELECT   = 8'h00;
  localparam logic [7:0] IDX_SOFTWARE_RST  = 8'h01;
  localparam logic [7:0] IDX_SAMPLE_RATE   = 8'h02;
  localparam logic [7:0] IDX_PLL_CONTROL_A = 8'h03;
  localparam logic [7:0] IDX_PLL_CONTROL_B = 8'h04;
  localparam logic [7:0] IDX_PLL_FRAC_HIGH = 8'h05;
  localparam logic [7:0] IDX_PLL_FRAC_LOW  = 8'h06;
  localparam logic [7:0] IDX_CLKOUT_CTRL   = 8'h66;
  localparam logic [7:0] IDX_CLKOUT_DIV    = 8'h07;

  // reset values
  localparam logic [7:0] RST_PAGE_SELECT   = 8'h00;
  localparam logic [7:0] RST_SAMPLE_RATE   = 8'h00;
  localparam logic [7:0] RST_PLL_CONTROL_A = 8'h10;
  localparam logic [7:0] RST_PLL_CONTROL_B = 8'h04;
  localparam logic [7:0] RST_PLL_FRAC_HIGH = 8'h00;
  localparam logic [7:0] RST_PLL_FRAC_LOW  = 8'h00;
  localparam logic [7:0] RST_CLKOUT_CTRL   = 8'h00;
  localparam logic [7:0] RST_CLKOUT_DIV    = 8'h00;

  // field positions
  localparam int unsigned PAGE_BIT       = 0;
  localparam int unsigned SWRST_BIT      = 7;
  localparam int unsigned PLL_EN_BIT     = 7;
  localparam int unsigned ADC_RATE_LSB   = 4;
  localparam int unsigned DAC_RATE_LSB   = 0;
  localparam int unsigned Q_LSB          = 3;
  localparam int unsigned P_LSB          = 0;
  localparam int unsigned J_LSB          = 2;
  localparam int unsigned DLOW_LSB       = 2;
  localparam int unsigned SRC_LSB        = 6;
  localparam int unsigned M_LSB          = 4;
  localparam int unsigned N_LSB          = 0;

  // reserved rate codes and divider decode constants
  localparam logic [3:0] RATE_CODE_MAX   = 4'hA;
  localparam logic [3:0] Q_CODE_16       = 4'h0;
  localparam logic [3:0] Q_CODE_17       = 4'h1;
  localparam logic [4:0] Q_VAL_16        = 5'h10;
  localparam logic [4:0] Q_VAL_17        = 5'h11;
  localparam logic [2:0] P_CODE_8        = 3'h0;
  localparam logic [3:0] P_VAL_8         = 4'h8;
  localparam logic [4:0] N_OFFSET        = 5'h02;
  localparam logic [13:0] D_MAX          = 14'h270F;

  // divider source select encodings
  typedef enum logic [1:0] {
    SRC_MASTER  = 2'h0,
    SRC_BIT     = 2'h1,
    SRC_AUX_PIN = 2'h2
  } div_source_e;

endpackage : codec_clock_pkg

// File: verilog/codec_clock_rate_regs.sv
// codec clock-rate control registers with decoded divider outputs
// assumes a classic wishbone master on sys_clk; one clock domain
//
// How it works
// R1: every register is eight bits, D7 msb
// R2: page bit D0 selects active page
// R3: host reads page bit back after writing
// R4: host writes zeros to reserved bits
// R5: reset bit self clears; zero ignored
// R6: host rewrites driver registers, not reset
// R7: adc divisor is one plus half code
// R8: dac divisor same table, resets to one
// R9: host never writes rate codes above 1010
// R10: pll enable bit, resets to zero
// R11: q codes 0,1 mean 16,17; else binary
// R12: p code 000 means eight
// R13: j is binary 1..63, resets to 1
// R14: d is 14 bits across two registers
// R15: host keeps d within 0..9999
// R16: host writes high then low part of d
// R17: clock-out m in 1,2,4,8; n 2..17
// R18: divider source select in two bits
// R19: pll off: ref rate is source/(128q)
// R20: pll on: ref rate is in*k*r/(2048p)
// R21: k is j plus d over ten thousand
// R22: d applied only on low-part write
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

module codec_clock_rate_regs (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  output logic             active_page,
  output logic             soft_reset_pulse,
  output logic [4:0]       adc_rate_half_div,
  output logic [4:0]       dac_rate_half_div,
  output logic             pll_enable,
  output logic [4:0]       pll_q_div,
  output logic [3:0]       pll_p_div,
  output logic [5:0]       pll_j_mult,
  output logic [13:0]      pll_d_frac,
  output logic             pll_d_update,
  output logic [1:0]       divider_source_clock,
  output logic [3:0]       clkout_m_div,
  output logic [4:0]       clkout_n_div
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  page_select;
    logic [7:0]  sample_rate_select;
    logic [7:0]  pll_control_a;
    logic [7:0]  pll_control_b;
    logic [7:0]  pll_fraction_high;
    logic [7:0]  pll_fraction_low;
    logic [7:0]  clkout_ctrl;
    logic [7:0]  clkout_div;
    logic [13:0] d_applied;
    logic        d_update;
    logic        swrst;
    logic [31:0] rdata;
    logic        ack;
    logic        err;
    logic [4:0]  adc_div;
    logic [4:0]  dac_div;
    logic [4:0]  q_div;
    logic [3:0]  p_div;
    logic [3:0]  m_div;
    logic [4:0]  n_div;
  } state_s;

  state_s st;
  state_s next_st;

  // ------------------------------------------------------------
  // decoded values and their reset levels
  // ------------------------------------------------------------
  localparam logic [4:0] RATE_HALF_BASE = 5'h02; // divisor 1.0 in half steps
  localparam logic [4:0] RST_Q_DIV      = 5'h02;
  localparam logic [3:0] M_UNIT         = 4'h1;

  // ------------------------------------------------------------
  // stored fields and write-data fields
  // ------------------------------------------------------------
  logic [3:0] adc_code;
  logic [3:0] dac_code;
  logic [3:0] q_code;
  logic [2:0] p_code;
  logic [5:0] j_code;
  logic [1:0] src_code;
  logic [1:0] m_code;
  logic [3:0] n_code;
  logic [7:0] wr_byte;
  logic [5:0] wr_j;
  logic [5:0] wr_d_low;
  logic [1:0] wr_src;

  assign adc_code = st.sample_rate_select[codec_clock_pkg::ADC_RATE_LSB +: 4]; // R7
  assign dac_code = st.sample_rate_select[codec_clock_pkg::DAC_RATE_LSB +: 4]; // R8
  assign q_code   = st.pll_control_a[codec_clock_pkg::Q_LSB +: 4]; // R11
  assign p_code   = st.pll_control_a[codec_clock_pkg::P_LSB +: 3]; // R12
  assign j_code   = st.pll_control_b[codec_clock_pkg::J_LSB +: 6]; // R13
  assign src_code = st.clkout_ctrl[codec_clock_pkg::SRC_LSB +: 2]; // R18
  assign m_code   = st.clkout_div[codec_clock_pkg::M_LSB +: 2]; // R17
  assign n_code   = st.clkout_div[codec_clock_pkg::N_LSB +: 4]; // R17
  assign wr_byte  = wb_dat_i[7:0]; // R1
  assign wr_j     = wb_dat_i[codec_clock_pkg::J_LSB +: 6];
  assign wr_d_low = wb_dat_i[codec_clock_pkg::DLOW_LSB +: 6];
  assign wr_src   = wb_dat_i[codec_clock_pkg::SRC_LSB +: 2];

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // rate divisor in half steps: 2 + code, so code 0 -> 2 (=1.0)
  function automatic logic [4:0] rate_half(input logic [3:0] code);
    logic [4:0] v;
    v = RATE_HALF_BASE + {1'b0, code};
    if (code > codec_clock_pkg::RATE_CODE_MAX) begin
      v = RATE_HALF_BASE + {1'b0, codec_clock_pkg::RATE_CODE_MAX};
    end
    return v;
  endfunction : rate_half

  function automatic logic [4:0] q_decode(input logic [3:0] code);
    logic [4:0] v;
    case (code)
      codec_clock_pkg::Q_CODE_16: begin
        v = codec_clock_pkg::Q_VAL_16;
      end
      codec_clock_pkg::Q_CODE_17: begin
        v = codec_clock_pkg::Q_VAL_17;
      end
      default: begin
        v = {1'b0, code};
      end
    endcase
    return v;
  endfunction : q_decode

  function automatic logic [3:0] p_decode(input logic [2:0] code);
    logic [3:0] v;
    case (code)
      codec_clock_pkg::P_CODE_8: begin
        v = codec_clock_pkg::P_VAL_8;
      end
      default: begin
        v = {1'b0, code};
      end
    endcase
    return v;
  endfunction : p_decode

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic [7:0] idx;
  logic       req;
  logic       wr_lane0;
  logic       hit;

  assign idx      = wb_adr_i[9:2];
  assign req      = wb_cyc_i && wb_stb_i && !st.ack && !st.err;
  assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.ack      = 1'b0;
    next_st.err      = 1'b0;
    next_st.swrst    = 1'b0;
    next_st.d_update = 1'b0;
    hit              = 1'b1;
    next_st.rdata    = 32'h0000_0000;

    // ----------------------------------------------------------
    // read mux and bus answer
    // ----------------------------------------------------------
    case (idx)
      codec_clock_pkg::IDX_PAGE_SELECT: begin
        next_st.rdata[7:0] = st.page_select;
      end
      codec_clock_pkg::IDX_SOFTWARE_RST: begin
        next_st.rdata[7:0] = 8'h00;
      end
      codec_clock_pkg::IDX_SAMPLE_RATE: begin
        next_st.rdata[7:0] = st.sample_rate_select;
      end
      codec_clock_pkg::IDX_PLL_CONTROL_A: begin
        next_st.rdata[7:0] = st.pll_control_a;
      end
      codec_clock_pkg::IDX_PLL_CONTROL_B: begin
        next_st.rdata[7:0] = st.pll_control_b;
      end
      codec_clock_pkg::IDX_PLL_FRAC_HIGH: begin
        next_st.rdata[7:0] = st.pll_fraction_high;
      end
      codec_clock_pkg::IDX_PLL_FRAC_LOW: begin
        next_st.rdata[7:0] = st.pll_fraction_low;
      end
      codec_clock_pkg::IDX_CLKOUT_CTRL: begin
        next_st.rdata[7:0] = st.clkout_ctrl;
      end
      codec_clock_pkg::IDX_CLKOUT_DIV: begin
        next_st.rdata[7:0] = st.clkout_div;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (req) begin
      next_st.ack = hit;
      next_st.err = !hit;
    end
    if (!req || wb_we_i || !hit) begin
      next_st.rdata = 32'h0000_0000;
    end

    // ----------------------------------------------------------
    // register writes
    // ----------------------------------------------------------
    if (wr_lane0 && hit) begin
      case (idx)
        codec_clock_pkg::IDX_PAGE_SELECT: begin
          next_st.page_select = {7'h00, wb_dat_i[codec_clock_pkg::PAGE_BIT]}; // R2
        end
        codec_clock_pkg::IDX_SOFTWARE_RST: begin
          next_st.swrst = wb_dat_i[codec_clock_pkg::SWRST_BIT]; // R5
        end
        codec_clock_pkg::IDX_SAMPLE_RATE: begin
          next_st.sample_rate_select = wr_byte;
        end
        codec_clock_pkg::IDX_PLL_CONTROL_A: begin
          next_st.pll_control_a = wr_byte;
        end
        codec_clock_pkg::IDX_PLL_CONTROL_B: begin
          next_st.pll_control_b = {wr_j, 2'h0}; // R13
        end
        codec_clock_pkg::IDX_PLL_FRAC_HIGH: begin
          next_st.pll_fraction_high = wr_byte;
        end
        codec_clock_pkg::IDX_PLL_FRAC_LOW: begin
          next_st.pll_fraction_low = {wr_d_low, 2'h0};
          next_st.d_applied = {st.pll_fraction_high, wr_d_low}; // R14 R22
          next_st.d_update  = 1'b1; // R22
        end
        codec_clock_pkg::IDX_CLKOUT_CTRL: begin
          next_st.clkout_ctrl = {wr_src, 6'h00}; // R18
        end
        codec_clock_pkg::IDX_CLKOUT_DIV: begin
          next_st.clkout_div = wr_byte;
        end
        default: begin
          next_st.swrst = 1'b0;
        end
      endcase
    end

    // ----------------------------------------------------------
    // software reset restores every register; strobe lasts one cycle
    // ----------------------------------------------------------
    if (st.swrst) begin // R5
      next_st.page_select        = codec_clock_pkg::RST_PAGE_SELECT;
      next_st.sample_rate_select = codec_clock_pkg::RST_SAMPLE_RATE;
      next_st.pll_control_a      = codec_clock_pkg::RST_PLL_CONTROL_A;
      next_st.pll_control_b      = codec_clock_pkg::RST_PLL_CONTROL_B;
      next_st.pll_fraction_high  = codec_clock_pkg::RST_PLL_FRAC_HIGH;
      next_st.pll_fraction_low   = codec_clock_pkg::RST_PLL_FRAC_LOW;
      next_st.clkout_ctrl        = codec_clock_pkg::RST_CLKOUT_CTRL;
      next_st.clkout_div         = codec_clock_pkg::RST_CLKOUT_DIV;
      next_st.d_applied          = 14'h0000;
    end

    // ----------------------------------------------------------
    // decoded dividers, registered from the stored fields
    // ----------------------------------------------------------
    next_st.adc_div = rate_half(adc_code); // R7
    next_st.dac_div = rate_half(dac_code); // R8
    next_st.q_div   = q_decode(q_code); // R11 R19
    next_st.p_div   = p_decode(p_code); // R12 R20
    next_st.m_div   = M_UNIT << m_code; // R17
    next_st.n_div   = {1'b0, n_code} + codec_clock_pkg::N_OFFSET; // R17
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st                    <= '0;
      st.sample_rate_select <= codec_clock_pkg::RST_SAMPLE_RATE;
      st.pll_control_a      <= codec_clock_pkg::RST_PLL_CONTROL_A; // R10 R11
      st.pll_control_b      <= codec_clock_pkg::RST_PLL_CONTROL_B; // R13
      st.adc_div            <= RATE_HALF_BASE;
      st.dac_div            <= RATE_HALF_BASE;
      st.q_div              <= RST_Q_DIV;
      st.p_div              <= codec_clock_pkg::P_VAL_8;
      st.m_div              <= M_UNIT;
      st.n_div              <= codec_clock_pkg::N_OFFSET;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign wb_dat_o             = st.rdata; // R1
  assign wb_ack_o             = st.ack;
  assign wb_err_o             = st.err;

  // ------------------------------------------------------------
  // clock control outputs
  // ------------------------------------------------------------
  assign active_page          = st.page_select[codec_clock_pkg::PAGE_BIT];
  assign soft_reset_pulse     = st.swrst;
  assign adc_rate_half_div    = st.adc_div;
  assign dac_rate_half_div    = st.dac_div;
  assign pll_enable           = st.pll_control_a[codec_clock_pkg::PLL_EN_BIT]; // R10
  assign pll_q_div            = st.q_div;
  assign pll_p_div            = st.p_div;
  assign pll_j_mult           = j_code; // R13 R21
  assign pll_d_frac           = st.d_applied; // R21
  assign pll_d_update         = st.d_update;
  assign divider_source_clock = src_code; // R18
  assign clkout_m_div         = st.m_div;
  assign clkout_n_div         = st.n_div;

endmodule : codec_clock_rate_regs

`default_nettype wire

// File: test/host_bus_model.sv
// wishbone classic host model for the clock-rate register block
// assumes one clock; bench calls xfer after reset release
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
  input  wire logic        sys_clk,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [9:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat,
  input  wire logic        ack,
  input  wire logic        err,
  input  wire logic [31:0] dq
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we  = 1'b0;
    adr = 10'h000;
    sel = 4'h0;
    dat = 32'h0000_0000;
  end
  // one request, held until ack or err, bounded wait
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
                      output logic [31:0] r, output logic e, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {i, 2'b00};
    sel <= 4'h1;
    dat <= {24'h00_0000, d};
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge sys_clk);
      ok = (ack === 1'b1) || (err === 1'b1);
    end
    r = dq;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    dat <= ~dat;
  endtask : xfer
endmodule : host_bus_model
`default_nettype wire

// File: test/codec_clock_chk.sv
// port checker for the clock-rate register block
// assumes sys_clk domain only, bound onto the top module
`timescale 1ns/10ps
`default_nettype none
module codec_clock_chk (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        wb_err_o,
  input  wire logic        soft_reset_pulse,
  input  wire logic [4:0]  adc_rate_half_div,
  input  wire logic [4:0]  dac_rate_half_div,
  input  wire logic [4:0]  pll_q_div,
  input  wire logic [3:0]  pll_p_div,
  input  wire logic [5:0]  pll_j_mult,
  input  wire logic [13:0] pll_d_frac,
  input  wire logic        pll_d_update,
  input  wire logic [3:0]  clkout_m_div
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o) else $error("request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_width: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data above bit 7");
  a_err_cause: assert property (wb_err_o |-> $past(wb_adr_i[9:2]) > 8'h07
    && $past(wb_adr_i[9:2]) != 8'h66) else $error("error on mapped index");
  a_rst_pulse: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("reset pulse not self clearing");
  a_rst_restore: assert property (soft_reset_pulse |-> ##[2:3]
    (pll_j_mult == 6'h01 && pll_q_div == 5'h02)) else $error("soft reset lost");
  a_rate_range: assert property (adc_rate_half_div inside {[5'h02:5'h0c]}
    && dac_rate_half_div inside {[5'h02:5'h0c]}) else $error("rate divisor out");
  a_q_range: assert property (pll_q_div inside {[5'h02:5'h11]})
    else $error("q out of range");
  a_p_range: assert property (pll_p_div inside {[4'h1:4'h8]})
    else $error("p out of range");
  a_j_nonzero: assert property (pll_j_mult != 6'h00)
    else $error("j is zero");
  a_m_set: assert property (clkout_m_div inside {4'h1, 4'h2, 4'h4, 4'h8})
    else $error("m not a power of two");
  a_frac_hold: assert property ($changed(pll_d_frac) |-> pll_d_update
    || $past(pll_d_update) || $past(soft_reset_pulse))
    else $error("fraction changed without update");
endmodule : codec_clock_chk
bind codec_clock_rate_regs codec_clock_chk u_chk (.*);
`default_nettype wire

// File: test/codec_clock_rate_regs_test.sv
// self-checking bench for the clock-rate register block
// assumes host_bus_model drives the wishbone side
`timescale 1ns/10ps
`default_nettype none
module codec_clock_rate_regs_test;
  logic        sys_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
  logic        active_page, soft_reset_pulse, pll_enable, pll_d_update;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, pll_p_div, clkout_m_div;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [4:0]  adc_rate_half_div, dac_rate_half_div, pll_q_div, clkout_n_div;
  logic [5:0]  pll_j_mult;
  logic [13:0] pll_d_frac;
  logic [1:0]  divider_source_clock;
  int          error_cnt = 0;
  int          cmp_count = 0;
  codec_clock_rate_regs u_dut (.sys_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .active_page,
    .soft_reset_pulse, .adc_rate_half_div, .dac_rate_half_div, .pll_enable, .pll_q_div,
    .pll_p_div, .pll_j_mult, .pll_d_frac, .pll_d_update, .divider_source_clock,
    .clkout_m_div, .clkout_n_div);
  host_bus_model u_host (.sys_clk(sys_clk), .cyc(wb_cyc_i), .stb(wb_stb_i), .we(wb_we_i),
    .adr(wb_adr_i), .sel(wb_sel_i), .dat(wb_dat_i), .ack(wb_ack_o), .err(wb_err_o),
    .dq(wb_dat_o));
  task automatic report_and_stop();
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    logic ok;
    u_host.xfer(w, i, d, r, e, ok);
    if (!ok) begin
      error_cnt++;
      report_and_stop();
    end
  endtask : bus
  // write, then let decoded outputs settle
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    bus(1'b1, i, d, r, e);
    repeat (3) @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    bus(1'b0, i, 8'h00, r, e);
    chk(r, {24'h00_0000, exp});
    chk({31'h0, e}, 32'h0000_0000);
  endtask : rd
  task automatic t_reset();
    rd(8'h00, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h10);
    rd(8'h04, 8'h04);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    chk({31'h0, pll_enable}, 32'h0000_0000);
    chk({28'h0, pll_p_div}, 32'h0000_0008);
  endtask : t_reset
  task automatic t_page();
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h01);
    chk({31'h0, active_page}, 32'h0000_0001);
    wr(8'h00, 8'h00);
    chk({31'h0, active_page}, 32'h0000_0000);
  endtask : t_page
  task automatic t_rates();
    for (int c = 0; c <= 10; c++) begin
      wr(8'h02, {4'(c), 4'(10 - c)});
      chk(32'(adc_rate_half_div), 32'(c + 2));
      chk(32'(dac_rate_half_div), 32'(12 - c));
    end
  endtask : t_rates
  task automatic t_pll();
    for (int c = 0; c < 16; c++) begin
      wr(8'h03, {1'b1, 4'(c), 3'(c)});
      chk(32'(pll_q_div), 32'(c < 2 ? c + 16 : c));
      chk(32'(pll_p_div), 32'(c % 8 == 0 ? 8 : c % 8));
      chk({31'h0, pll_enable}, 32'h0000_0001);
    end
    wr(8'h04, 8'hff);
    rd(8'h04, 8'hfc);
    chk(32'(pll_j_mult), 32'h0000_003f);
  endtask : t_pll
  task automatic t_frac();
    wr(8'h05, 8'h9c);
    chk(32'(pll_d_frac), 32'h0000_0000);
    wr(8'h06, 8'h3c);
    chk(32'(pll_d_frac), 32'd9999);
    rd(8'h06, 8'h3c);
  endtask : t_frac
  task automatic t_clkout();
    logic [31:0] r;
    logic        e;
    wr(8'h66, 8'h80);
    chk(32'(divider_source_clock), 32'h0000_0002);
    wr(8'h07, 8'h35);
    chk(32'(clkout_m_div), 32'h0000_0008);
    chk(32'(clkout_n_div), 32'h0000_0007);
    bus(1'b0, 8'h20, 8'h00, r, e);
    chk({31'h0, e}, 32'h0000_0001);
  endtask : t_clkout
  task automatic t_swrst();
    wr(8'h01, 8'h00);
    chk(32'(pll_j_mult), 32'h0000_003f);
    wr(8'h01, 8'h80);
    repeat (3) @(posedge sys_clk);
    chk(32'(pll_j_mult), 32'h0000_0001);
    chk(32'(pll_d_frac), 32'h0000_0000);
    rd(8'h03, 8'h10);
  endtask : t_swrst
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    resetn = 1'b0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_page();
    t_rates();
    t_pll();
    t_frac();
    t_clkout();
    t_swrst();
    report_and_stop();
  end
endmodule : codec_clock_rate_regs_test
`default_nettype wire
